// file: design/serial_map.vh
`ifndef SERIAL_MAP_VH
`define SERIAL_MAP_VH

// ********************************************
// Register offsets
// ********************************************
`define OFS_POWER_CONTROL 8'h87
`define OFS_SERIAL_CONTROL 8'h98
`define OFS_SERIAL_BUFFER 8'h99
`define OFS_SLAVE_ADDRESS 8'ha9
`define OFS_SLAVE_ADDRESS_MASK 8'hb9

// ********************************************
// Reset values
// ********************************************
`define RST_SLAVE_ADDRESS 8'h00
`define RST_SLAVE_ADDRESS_MASK 8'h00
`define RST_BYTE 8'h00

// ********************************************
// Serial control fields
// ********************************************
`define SC_BIT7 7
`define SC_MODE1 6
`define SC_MULTIPROC 5
`define SC_RX_ENABLE 4
`define SC_TX_NINTH 3
`define SC_RX_NINTH 2
`define SC_TX_DONE 1
`define SC_RX_DONE 0

// ********************************************
// Power control fields
// ********************************************
`define PC_BAUD_DOUBLE 7
`define PC_FLAG_VIEW 6

// ********************************************
// Modes, periods in clocks, sample points in sixteenth-bit ticks, frame bit counts
// ********************************************
`define MODE_SYNC 2'h0
`define MODE_ASYNC10 2'h1
`define MODE_ASYNC11_FIXED 2'h2
`define MODE_ASYNC11_TIMER 2'h3
`define SYNC_PERIOD_SLOW 4'hc
`define SYNC_PERIOD_FAST 4'h4
`define FIXED_TICK_SLOW 2'h3
`define FIXED_TICK_FAST 2'h1
`define SAMPLE_FIRST 4'h8
`define SAMPLE_SECOND 4'h9
`define SAMPLE_THIRD 4'ha
`define BITS_ASYNC10 4'ha
`define BITS_ASYNC11 4'hb
`define BITS_SYNC 4'h8

`endif

// file: design/addr_match.v
`timescale 1ns/1ps

module addr_match #(
	parameter WIDTH = 8
) (
	// Received byte
	input wire [WIDTH-1:0] rx_byte,
	// Address setup
	input wire [WIDTH-1:0] slave_address,
	input wire [WIDTH-1:0] slave_address_mask,
	// Result
	output wire match
);

	wire [WIDTH-1:0] bcast;
	wire [WIDTH-1:0] given_hit;
	wire [WIDTH-1:0] bcast_hit;

	assign bcast = slave_address | slave_address_mask;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			// Masked-off positions always agree
			assign given_hit[i] = ~slave_address_mask[i] |
				(rx_byte[i] == slave_address[i]);
			assign bcast_hit[i] = ~bcast[i] | rx_byte[i];
		end
	endgenerate

	assign match = (&given_hit) | (&bcast_hit);

endmodule

// file: design/serial_port.v
`timescale 1ns/1ps
`include "serial_map.vh"

module serial_port (
	// Clock and reset
	input wire clk_sys,
	input wire rstn,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Baud timer overflow pulse
	input wire timer_ovf,
	// Serial pins
	output wire tx_out,
	input wire rx_in,
	output wire rx_out,
	output wire rx_oe
);

	localparam RX_IDLE = 1'b0;
	localparam RX_RUN = 1'b1;

	// ********************************************
	// Registers
	// ********************************************
	reg mode_select_bit0_reg;
	reg mode_select_bit1_reg;
	reg multiproc_enable_reg;
	reg rx_enable_reg;
	reg tx_ninth_reg;
	reg rx_ninth_bit_reg;
	reg tx_done_reg;
	reg rx_done_flag_reg;
	reg frame_error_flag_reg;
	reg baud_double_select_reg;
	reg flag_view_select_reg;
	reg [7:0] slave_address_reg;
	reg [7:0] slave_address_mask_reg;
	reg [7:0] rx_buf_reg;

	wire [1:0] mode;
	wire wr_sc;
	wire wr_serial_buffer;
	wire wr_pc;
	wire sync_mode;

	assign mode = {mode_select_bit0_reg, mode_select_bit1_reg};
	assign sync_mode = (mode == `MODE_SYNC);
	assign wr_sc = reg_wr && (reg_addr == `OFS_SERIAL_CONTROL);
	assign wr_serial_buffer = reg_wr && (reg_addr == `OFS_SERIAL_BUFFER);
	assign wr_pc = reg_wr && (reg_addr == `OFS_POWER_CONTROL);

	// ********************************************
	// Pin synchroniser
	// ********************************************
	reg rx_meta_reg;
	reg rx_sync_reg;
	reg rx_prev_reg;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_meta_reg <= rx_in;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
		end
	end

	// ********************************************
	// Sixteen-times bit tick
	// ********************************************
	reg [1:0] fixed_cnt_reg;
	reg ovf_half_reg;
	wire fixed_tick;
	wire timer_tick;
	wire tick16;
	wire [1:0] fixed_top;

	assign fixed_top = baud_double_select_reg ? `FIXED_TICK_FAST :
		`FIXED_TICK_SLOW;
	assign fixed_tick = (fixed_cnt_reg == fixed_top);
	// Without doubling only every second overflow counts
	assign timer_tick = timer_ovf && (baud_double_select_reg || ovf_half_reg);
	assign tick16 = (mode == `MODE_ASYNC11_FIXED) ? fixed_tick :
		timer_tick;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fixed_cnt_reg <= 2'h0;
			ovf_half_reg <= 1'b0;
		end else begin
			fixed_cnt_reg <= fixed_tick ? 2'h0 : fixed_cnt_reg + 2'h1;
			if (timer_ovf)
				ovf_half_reg <= ~ovf_half_reg;
		end
	end

	// ********************************************
	// Synchronous mode engine
	// ********************************************
	reg sync_busy_reg;
	reg sync_rx_reg;
	reg [3:0] sync_phase_reg;
	reg [3:0] sync_bits_reg;
	reg [7:0] sync_sh_reg;
	wire [3:0] sync_top;
	wire [3:0] sync_fall;
	wire [3:0] sync_rise;
	wire sync_clk_low;
	wire sync_rx_start;
	wire sync_end;
	wire sync_rx_set;
	wire sync_tx_set;

	assign sync_top = multiproc_enable_reg ? `SYNC_PERIOD_FAST :
		`SYNC_PERIOD_SLOW;
	assign sync_fall = {2'b00, sync_top[3:2]};
	assign sync_rise = sync_fall + {1'b0, sync_top[3:1]};
	assign sync_clk_low = sync_busy_reg && (sync_phase_reg >= sync_fall) &&
		(sync_phase_reg < sync_rise);
	assign sync_rx_start = sync_mode && rx_enable_reg && !rx_done_flag_reg &&
		!sync_busy_reg && !wr_serial_buffer;
	assign sync_end = sync_busy_reg && (sync_phase_reg == sync_top - 4'h1) &&
		(sync_bits_reg == `BITS_SYNC - 4'h1);
	assign sync_rx_set = sync_end && sync_rx_reg;
	assign sync_tx_set = sync_end && !sync_rx_reg;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sync_busy_reg <= 1'b0;
			sync_rx_reg <= 1'b0;
			sync_phase_reg <= 4'h0;
			sync_bits_reg <= 4'h0;
			sync_sh_reg <= `RST_BYTE;
		end else if (wr_serial_buffer && sync_mode) begin
			sync_busy_reg <= 1'b1;
			sync_rx_reg <= 1'b0;
			sync_phase_reg <= 4'h0;
			sync_bits_reg <= 4'h0;
			sync_sh_reg <= reg_wdata;
		end else if (sync_rx_start) begin
			sync_busy_reg <= 1'b1;
			sync_rx_reg <= 1'b1;
			sync_phase_reg <= 4'h0;
			sync_bits_reg <= 4'h0;
		end else if (sync_busy_reg) begin
			// Receive latches on the rising shift clock edge
			if (sync_rx_reg && (sync_phase_reg == sync_rise))
				sync_sh_reg <= {rx_sync_reg, sync_sh_reg[7:1]};
			if (sync_phase_reg == sync_top - 4'h1) begin
				sync_phase_reg <= 4'h0;
				sync_bits_reg <= sync_bits_reg + 4'h1;
				if (!sync_rx_reg)
					sync_sh_reg <= {1'b1, sync_sh_reg[7:1]};
				if (sync_end)
					sync_busy_reg <= 1'b0;
			end else begin
				sync_phase_reg <= sync_phase_reg + 4'h1;
			end
		end
	end

	// ********************************************
	// Asynchronous transmitter
	// ********************************************
	reg [3:0] tx_div_reg;
	reg [10:0] tx_sh_reg;
	reg [3:0] tx_left_reg;
	reg tx_busy_reg;
	reg tx_line_reg;
	wire tx_roll;
	wire tx_async_set;

	// Bits leave on the divide-by-16 rollover, not on the write itself
	assign tx_roll = tick16 && (tx_div_reg == 4'hf);
	assign tx_async_set = tx_roll && tx_busy_reg && (tx_left_reg == 4'h1);

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tx_div_reg <= 4'h0;
			tx_sh_reg <= 11'h7ff;
			tx_left_reg <= 4'h0;
			tx_busy_reg <= 1'b0;
			tx_line_reg <= 1'b1;
		end else begin
			if (tick16)
				tx_div_reg <= tx_div_reg + 4'h1;
			if (wr_serial_buffer && !sync_mode) begin
				tx_busy_reg <= 1'b1;
				if (mode == `MODE_ASYNC10) begin
					tx_sh_reg <= {2'b11, reg_wdata, 1'b0};
					tx_left_reg <= `BITS_ASYNC10;
				end else begin
					tx_sh_reg <= {1'b1, tx_ninth_reg, reg_wdata, 1'b0};
					tx_left_reg <= `BITS_ASYNC11;
				end
			end else if (tx_roll && tx_busy_reg) begin
				if (tx_left_reg != 4'h0) begin
					tx_line_reg <= tx_sh_reg[0];
					tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
					tx_left_reg <= tx_left_reg - 4'h1;
				end else begin
					tx_busy_reg <= 1'b0;
				end
			end
		end
	end

	// ********************************************
	// Asynchronous receiver
	// ********************************************
	reg rx_state_reg;
	reg [3:0] rx_div_reg;
	reg [3:0] rx_bitn_reg;
	reg rx_s8_reg;
	reg rx_s9_reg;
	reg [7:0] rx_data_reg;
	reg rx_ninth_tmp_reg;
	wire rx_fall;
	wire vote;
	wire at_vote;
	wire [3:0] rx_last;
	wire at_stop;
	wire addr_hit;
	wire mp_ok;
	wire frame_accept;
	wire frame_bad;
	wire ninth_in;

	assign rx_fall = rx_prev_reg && !rx_sync_reg;
	assign vote = (rx_s8_reg & rx_s9_reg) | (rx_s8_reg & rx_sync_reg) |
		(rx_s9_reg & rx_sync_reg);
	assign at_vote = (rx_state_reg == RX_RUN) && tick16 &&
		(rx_div_reg == `SAMPLE_THIRD);
	assign rx_last = (mode == `MODE_ASYNC10) ? `BITS_ASYNC10 - 4'h1 :
		`BITS_ASYNC11 - 4'h1;
	assign at_stop = at_vote && (rx_bitn_reg == rx_last);
	assign ninth_in = (mode == `MODE_ASYNC10) ? vote : rx_ninth_tmp_reg;

	addr_match #(
		.WIDTH(8)
	) u_addr_match (
		.rx_byte(rx_data_reg),
		.slave_address(slave_address_reg),
		.slave_address_mask(slave_address_mask_reg),
		.match(addr_hit)
	);

	// Address frames in modes 2 and 3 carry a high ninth bit
	assign mp_ok = !multiproc_enable_reg || (vote && addr_hit &&
		((mode == `MODE_ASYNC10) || rx_ninth_tmp_reg));
	assign frame_accept = at_stop && !rx_done_flag_reg &&
		mp_ok;
	assign frame_bad = at_stop && !vote;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_state_reg <= RX_IDLE;
			rx_div_reg <= 4'h0;
			rx_bitn_reg <= 4'h0;
			rx_s8_reg <= 1'b1;
			rx_s9_reg <= 1'b1;
			rx_data_reg <= `RST_BYTE;
			rx_ninth_tmp_reg <= 1'b0;
		end else begin
			case (rx_state_reg)
			RX_IDLE: begin
				if (!sync_mode && rx_enable_reg && rx_fall) begin
					rx_state_reg <= RX_RUN;
					rx_div_reg <= 4'h0;
					rx_bitn_reg <= 4'h0;
				end
			end
			RX_RUN: begin
				if (tick16) begin
					rx_div_reg <= rx_div_reg + 4'h1;
					if (rx_div_reg == `SAMPLE_FIRST)
						rx_s8_reg <= rx_sync_reg;
					if (rx_div_reg == `SAMPLE_SECOND)
						rx_s9_reg <= rx_sync_reg;
				end
				if (at_vote) begin
					rx_bitn_reg <= rx_bitn_reg + 4'h1;
					if (rx_bitn_reg == 4'h0) begin
						if (vote)
							rx_state_reg <= RX_IDLE;
					end else if (at_stop) begin
						rx_state_reg <= RX_IDLE;
					end else if (rx_bitn_reg == 4'h9) begin
						rx_ninth_tmp_reg <= vote;
					end else begin
						rx_data_reg <= {vote, rx_data_reg[7:1]};
					end
				end
				if (sync_mode)
					rx_state_reg <= RX_IDLE;
			end
			default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// ********************************************
	// Control and flag registers
	// ********************************************
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_select_bit0_reg <= 1'b0;
			mode_select_bit1_reg <= 1'b0;
			multiproc_enable_reg <= 1'b0;
			rx_enable_reg <= 1'b0;
			tx_ninth_reg <= 1'b0;
			rx_ninth_bit_reg <= 1'b0;
			tx_done_reg <= 1'b0;
			rx_done_flag_reg <= 1'b0;
			frame_error_flag_reg <= 1'b0;
			baud_double_select_reg <= 1'b0;
			flag_view_select_reg <= 1'b0;
			slave_address_reg <= `RST_SLAVE_ADDRESS;
			slave_address_mask_reg <= `RST_SLAVE_ADDRESS_MASK;
			rx_buf_reg <= `RST_BYTE;
		end else begin
			if (wr_sc) begin
				if (!flag_view_select_reg)
					mode_select_bit0_reg <= reg_wdata[`SC_BIT7];
				mode_select_bit1_reg <= reg_wdata[`SC_MODE1];
				multiproc_enable_reg <= reg_wdata[`SC_MULTIPROC];
				rx_enable_reg <= reg_wdata[`SC_RX_ENABLE];
				tx_ninth_reg <= reg_wdata[`SC_TX_NINTH];
			end
			// Hardware events win over a same-cycle software clear
			if (frame_accept || sync_rx_set)
				rx_done_flag_reg <= 1'b1;
			else if (wr_sc)
				rx_done_flag_reg <= reg_wdata[`SC_RX_DONE];
			if (tx_async_set || sync_tx_set)
				tx_done_reg <= 1'b1;
			else if (wr_sc)
				tx_done_reg <= reg_wdata[`SC_TX_DONE];
			if (frame_accept)
				rx_ninth_bit_reg <= ninth_in;
			else if (wr_sc)
				rx_ninth_bit_reg <= reg_wdata[`SC_RX_NINTH];
			if (frame_bad)
				frame_error_flag_reg <= 1'b1;
			else if (wr_sc && flag_view_select_reg && !reg_wdata[`SC_BIT7])
				frame_error_flag_reg <= 1'b0;
			if (frame_accept)
				rx_buf_reg <= rx_data_reg;
			else if (sync_rx_set)
				// At the fast rate the last bit lands in this same cycle
				rx_buf_reg <= (sync_phase_reg == sync_rise) ?
					{rx_sync_reg, sync_sh_reg[7:1]} : sync_sh_reg;
			if (wr_pc) begin
				baud_double_select_reg <= reg_wdata[`PC_BAUD_DOUBLE];
				flag_view_select_reg <= reg_wdata[`PC_FLAG_VIEW];
			end
			if (reg_wr && (reg_addr == `OFS_SLAVE_ADDRESS))
				slave_address_reg <= reg_wdata;
			if (reg_wr && (reg_addr == `OFS_SLAVE_ADDRESS_MASK))
				slave_address_mask_reg <= reg_wdata;
		end
	end

	// ********************************************
	// Read port
	// ********************************************
	reg [7:0] rdata_next;
	wire bit7_view;

	assign bit7_view = flag_view_select_reg ? frame_error_flag_reg :
		mode_select_bit0_reg;

	always @* begin
		rdata_next = 8'h00;
		case (reg_addr)
		`OFS_SERIAL_CONTROL: rdata_next = {bit7_view, mode_select_bit1_reg,
			multiproc_enable_reg, rx_enable_reg, tx_ninth_reg,
			rx_ninth_bit_reg, tx_done_reg, rx_done_flag_reg};
		`OFS_SERIAL_BUFFER: rdata_next = rx_buf_reg;
		`OFS_POWER_CONTROL: rdata_next = {baud_double_select_reg,
			flag_view_select_reg, 6'h00};
		`OFS_SLAVE_ADDRESS: rdata_next = slave_address_reg;
		`OFS_SLAVE_ADDRESS_MASK: rdata_next = slave_address_mask_reg;
		default: rdata_next = 8'h00;
		endcase
	end

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= 8'h00;
	end

	// ********************************************
	// Pin drive
	// ********************************************
	// Sync mode owns the data pin only while shifting out
	assign tx_out = sync_mode ? !sync_clk_low : tx_line_reg;
	assign rx_oe = sync_mode && sync_busy_reg && !sync_rx_reg;
	assign rx_out = rx_oe ? sync_sh_reg[0] : 1'b1;

endmodule

// file: testbench/serial_port_monitor.sv
`timescale 1ns/1ps

module serial_port_monitor (
	// Clock and reset
	input wire clk_sys,
	input wire rstn,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// Baud timer and serial pins
	input wire timer_ovf,
	input wire tx_out,
	input wire rx_in,
	input wire rx_out,
	input wire rx_oe
);
	// ****************************************
	// Shadow of software settings
	// ****************************************
	reg mode0_q, mode1_q, mp_q, view_q, dbl_q;
	reg [7:0] sa_q, sm_q, zero_run;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			{mode0_q, mode1_q, mp_q, view_q, dbl_q} <= 5'h00;
			sa_q <= 8'h00;
			sm_q <= 8'h00;
			zero_run <= 8'h00;
		end else begin
			zero_run <= tx_out ? 8'h00 : zero_run + 8'h01;
			if (reg_wr && reg_addr == 8'h87) begin
				dbl_q <= reg_wdata[7];
				view_q <= reg_wdata[6];
			end
			if (reg_wr && reg_addr == 8'h98) begin
				// Mode bit 0 is only reachable with the flag view off
				if (!view_q)
					mode0_q <= reg_wdata[7];
				mode1_q <= reg_wdata[6];
				mp_q <= reg_wdata[5];
			end
			if (reg_wr && reg_addr == 8'ha9)
				sa_q <= reg_wdata;
			if (reg_wr && reg_addr == 8'hb9)
				sm_q <= reg_wdata;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_async_wr;
		reg_wr && reg_addr == 8'h99 && mode0_q && !mode1_q && dbl_q;
	endsequence
	sequence s_sync_wr;
		reg_wr && reg_addr == 8'h99 && !mode0_q && !mode1_q;
	endsequence
	sequence s_start_due;
		##[1:34] !tx_out;
	endsequence

	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	chk_slave_address_read: assert property (
		reg_rd && reg_addr == 8'ha9 |=> reg_rdata == sa_q)
		else $error("slave address readback wrong");
	chk_mask_read: assert property (
		reg_rd && reg_addr == 8'hb9 |=> reg_rdata == sm_q)
		else $error("address mask readback wrong");
	chk_unmapped_read: assert property (reg_rd && !(reg_addr inside
		{8'h87, 8'h98, 8'h99, 8'ha9, 8'hb9}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_async_start: assert property (s_async_wr |-> s_start_due)
		else $error("no start bit after buffer write");
	chk_sync_start: assert property (s_sync_wr |-> ##[1:3] rx_oe)
		else $error("no shift-out after buffer write");
	chk_bit_time: assert property ($rose(tx_out) && mode0_q &&
		!mode1_q && dbl_q |-> zero_run[4:0] == 5'h00 && zero_run != 8'h00)
		else $error("line bit time not 32 clocks");
	chk_shift_low: assert property ($rose(tx_out) && !mode0_q &&
		!mode1_q |-> zero_run == (mp_q ? 8'h02 : 8'h06))
		else $error("shift clock low time wrong");
	chk_data_idle: assert property (!rx_oe |-> rx_out)
		else $error("data pin output not high when undriven");
endmodule

// file: testbench/serial_peer.sv
`timescale 1ns/1ps

module serial_peer #(
	parameter BIT_CLKS = 32
) (
	// Clock
	input wire clk_sys,
	// Pins seen from the far side
	input wire shift_clk,
	output logic line_out
);
	// ****************************************
	// Far-side serial device
	// ****************************************
	// Data pin has a pull-up, so a released line reads high
	initial line_out = 1'b1;

	task automatic send(input [7:0] b, input nine, input has9, input stop);
		logic [10:0] f;
		int i;
		f = has9 ? {stop, nine, b, 1'b0} : {1'b1, stop, b, 1'b0};
		for (i = 0; i < (has9 ? 11 : 10); i++) begin
			@(posedge clk_sys);
			line_out <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		line_out <= 1'b1;
	endtask

	// Shift-register partner: new bit after each falling shift clock
	task automatic sync_send(input [7:0] b);
		int i, t;
		t = 0;
		for (i = 0; i < 8; i++) begin
			while (shift_clk !== 1'b0 && t < 500) begin
				@(posedge clk_sys);
				t++;
			end
			line_out <= b[i];
			while (shift_clk !== 1'b1 && t < 500) begin
				@(posedge clk_sys);
				t++;
			end
		end
		line_out <= 1'b1;
	endtask
endmodule

// file: testbench/serial_port_addr_recognition_test.sv
`timescale 1ns/1ps

module serial_port_addr_recognition_test;
	logic clk_sys, rstn, reg_wr, reg_rd, timer_ovf, peer_line;
	logic [7:0] reg_addr, reg_wdata;
	wire [7:0] reg_rdata;
	wire tx_out, rx_out, rx_oe, rx_pin;
	int n_fail, check_count;
	logic [7:0] t_ctl [9] = '{8'hb0, 8'hb0, 8'hb0, 8'hf0, 8'hf0, 8'hf0,
		8'h70, 8'h70, 8'hd0};
	logic [7:0] t_byte [9] = '{8'ha0, 8'ha2, 8'hff, 8'ha5, 8'ha6, 8'ha0,
		8'ha0, 8'ha0, 8'ha6};
	logic [8:0] t_nine = 9'b001011111;
	logic [8:0] t_hit = 9'b101001101;

	assign rx_pin = rx_oe ? rx_out : peer_line;

	serial_port serial_port_inst (.clk_sys(clk_sys), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_ovf(timer_ovf),
		.tx_out(tx_out), .rx_in(rx_pin), .rx_out(rx_out), .rx_oe(rx_oe));
	serial_peer serial_peer_inst (.clk_sys(clk_sys), .shift_clk(tx_out),
		.line_out(peer_line));

	// ****************************************
	// Clock, timer, bus tasks
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Overflow every second clock gives the same 32-clock bit as mode 2
	always @(posedge clk_sys) timer_ovf <= ~timer_ovf;

	task automatic chk(input [7:0] got, input [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input [7:0] a, input [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input [7:0] a, input [7:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic stop_test;
		$display("checks=%0d fails=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rdc(8'ha9, 8'h00);
		rdc(8'hb9, 8'h00);
		wr(8'h5c, 8'hff);
		rdc(8'h5c, 8'h00);
		wr(8'ha9, 8'ha4);
		wr(8'hb9, 8'hfa);
		rdc(8'ha9, 8'ha4);
		rdc(8'hb9, 8'hfa);
	endtask
	task automatic t_rx;
		wr(8'h87, 8'h80);
		wr(8'h98, 8'h80);
		serial_peer_inst.send(8'h77, 1'b0, 1'b1, 1'b1);
		rdc(8'h98, 8'h80);
		wr(8'h98, 8'h90);
		serial_peer_inst.send(8'h5a, 1'b0, 1'b1, 1'b1);
		repeat (4) @(posedge clk_sys);
		rdc(8'h98, 8'h91);
		rdc(8'h99, 8'h5a);
		serial_peer_inst.send(8'h33, 1'b1, 1'b1, 1'b1);
		rdc(8'h99, 8'h5a);
		rdc(8'h98, 8'h91);
	endtask
	task automatic t_fe;
		wr(8'h87, 8'hc0);
		wr(8'h98, 8'h10);
		rdc(8'h98, 8'h10);
		serial_peer_inst.send(8'h3c, 1'b0, 1'b1, 1'b0);
		repeat (4) @(posedge clk_sys);
		rdc(8'h98, 8'h91);
		wr(8'h98, 8'h90);
		serial_peer_inst.send(8'h3c, 1'b1, 1'b1, 1'b1);
		repeat (4) @(posedge clk_sys);
		rdc(8'h98, 8'h95);
		wr(8'h98, 8'h10);
		rdc(8'h98, 8'h10);
		wr(8'h87, 8'h80);
		rdc(8'h98, 8'h90);
	endtask
	task automatic t_table;
		int i;
		logic [7:0] e;
		for (i = 0; i < 9; i++) begin
			wr(8'h98, t_ctl[i]);
			serial_peer_inst.send(t_byte[i], t_nine[i], t_ctl[i][7],
				t_ctl[i][7] | t_nine[i]);
			repeat (4) @(posedge clk_sys);
			e = t_hit[i] ? t_ctl[i] | {5'h00, t_nine[i], 2'h1} : t_ctl[i];
			rdc(8'h98, e);
			if (t_hit[i])
				rdc(8'h99, t_byte[i]);
		end
	endtask
	task automatic t_tx;
		logic [10:0] f;
		int i, t;
		f = {1'b1, 1'b1, 8'h55, 1'b0};
		wr(8'h98, 8'h98);
		wr(8'h99, 8'h55);
		t = 0;
		while (tx_out !== 1'b0 && t < 100) begin
			@(posedge clk_sys);
			t++;
		end
		repeat (16) @(posedge clk_sys);
		for (i = 0; i < 11; i++) begin
			chk({7'h00, tx_out}, {7'h00, f[i]});
			repeat (32) @(posedge clk_sys);
		end
		rdc(8'h98, 8'h9a);
	endtask
	task automatic t_m0;
		int i, j, t;
		logic [7:0] d;
		fork
			serial_peer_inst.sync_send(8'hc3);
			wr(8'h98, 8'h10);
		join
		repeat (4) @(posedge clk_sys);
		rdc(8'h98, 8'h11);
		rdc(8'h99, 8'hc3);
		// Second pass runs the shift clock at the fast rate, receiver off
		for (j = 0; j < 2; j++) begin
			d = j ? 8'h5a : 8'h96;
			if (j)
				wr(8'h98, 8'h21);
			wr(8'h99, d);
			for (i = 0; i < 8; i++) begin
				t = 0;
				while (tx_out !== 1'b0 && t < 40) begin
					@(posedge clk_sys);
					t++;
				end
				while (tx_out !== 1'b1 && t < 40) begin
					@(posedge clk_sys);
					t++;
				end
				chk({7'h00, rx_out}, {7'h00, d[i]});
			end
			repeat (8) @(posedge clk_sys);
			rdc(8'h98, j ? 8'h23 : 8'h13);
		end
	endtask

	initial begin
		rstn = 1'b0;
		{reg_wr, reg_rd, timer_ovf} = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		n_fail = 0;
		check_count = 0;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset;
		t_rx;
		t_fe;
		t_table;
		t_tx;
		t_m0;
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		stop_test;
	end
endmodule

bind serial_port serial_port_monitor serial_port_monitor_inst (
	.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .timer_ovf(timer_ovf), .tx_out(tx_out),
	.rx_in(rx_in), .rx_out(rx_out), .rx_oe(rx_oe));
